// >>> hdl/asmm_pkg.sv
// shared constants and types of the axis safe motion monitor
package asmm_pkg;
  // ****************************************************************
  // clock and time base
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_NS = 100_000; // tolerance and delay unit
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  // ****************************************************************
  // element counts and widths
  // ****************************************************************
  localparam int NUM_LIM = 12;
  localparam int NUM_RNG = 2;
  localparam int NUM_DIR = 2;
  localparam int NUM_SOS = 3;
  localparam int NUM_TOL = NUM_LIM + NUM_RNG;
  localparam int SPD_W = 16;
  localparam int EXT_W = SPD_W + 2; // room for limit plus tolerance amount
  localparam int POS_W = 32;
  localparam int TIM_W = 16;
  localparam int PCT_W = 8;
  localparam int PCT_FULL = 100;
  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int DIR_POS = 0; // element allowed to move positive
  localparam int DIR_NEG = 1; // element allowed to move negative
  localparam logic RST_OUT = 1'h0; // every monitoring output starts off
  // stop sequences share one gray-coded state type
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RAMP = 2'h1,
    ST_HOLD = 2'h3,
    ST_TRIP = 2'h2
  } asmm_stop_t;
endpackage

// >>> hdl/asmm_tol.sv
// overshoot tolerance judge for one speed limit or one speed range
module asmm_tol (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic tick_in,
  input wire logic over_in,
  input wire logic excess_in,
  input wire logic [asmm_pkg::TIM_W-1:0] t1_in,
  input wire logic [asmm_pkg::TIM_W-1:0] t2_in,
  output logic viol_out
);
  typedef struct packed {
    logic [asmm_pkg::TIM_W-1:0] win;
    logic [asmm_pkg::TIM_W-1:0] acc;
    logic [asmm_pkg::TIM_W-1:0] gap;
    logic seen;
    logic over_q;
    logic viol;
  } asmm_tol_st_t;
  asmm_tol_st_t r, n;
  // ****************************************************************
  // overshoot bookkeeping
  // ****************************************************************
  // window counts the period from the overshoot that opened it
  always_comb begin
    n = r;
    n.over_q = over_in;
    if (tick_in) begin
      if (r.win != '0) begin
        n.win = (r.win >= t2_in) ? '0 : r.win + 1'b1;
      end
      if (over_in && r.acc != '1) begin
        n.acc = r.acc + 1'b1;
      end
      if (!over_in && r.gap != '1) begin
        n.gap = r.gap + 1'b1; // saturates so an old gap never wraps short
      end
    end
    // a fresh overshoot is judged on its gap even while a window is open
    if (over_in && !r.over_q) begin
      if (r.seen && r.gap < t2_in) begin
        n.viol = 1'b1; // R05
      end
      // placed after the tick update so a new period always starts with win at one and acc at zero
      if (r.win == '0) begin
        n.win = {{(asmm_pkg::TIM_W-1){1'b0}}, 1'b1};
        n.acc = '0;
      end
    end
    if (over_in) begin
      n.gap = '0;
      n.seen = 1'b1;
      if (r.acc >= t1_in) begin
        n.viol = 1'b1; // R04
      end
      if (excess_in) begin
        n.viol = 1'b1; // R06
      end
    end else begin
      n.viol = 1'b0; // verdict lasts only while the overshoot lasts
    end
  end
  // state register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
  assign viol_out = r.viol;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  AST_TOL_EXCESS: assert property (over_in && excess_in |=> viol_out) // R06
    else $error("excess overshoot not flagged");
  AST_TOL_TIME: assert property (over_in && r.acc >= t1_in |=> viol_out) // R04
    else $error("tolerance time overrun not flagged");
  AST_TOL_GAP: assert property (over_in && !r.over_q && r.seen && r.gap < t2_in // R05
    |=> viol_out) else $error("close repeat overshoot not flagged");
endmodule

// >>> hdl/asmm_top.sv
// single-axis safe motion monitor: speed, range, direction, standstill, stops
// Contract
// R01: speed limit enable drops when speed rises above its limit.
// R02: manual reset limit output waits for in-limit speed with hysteresis and reset.
// R03: twelve independently configured speed limits.
// R04: accumulated overshoot time per tolerance period must not pass tolerance time.
// R05: overshoots closer than tolerance period to previous one are violations.
// R06: overshoot beyond tolerance percentage switches output off at once.
// R07: range enable drops while speed lies outside min to max.
// R08: automatic range output returns once speed is back inside with hysteresis.
// R09: manual reset range output waits for in-range speed with hysteresis and reset.
// R10: two independently configured speed ranges.
// R11: direction check arms on start and trips on opposite motion beyond tolerance.
// R12: direction and standstill checks re-arm on start rising edge, latching position.
// R13: one direction element for positive and one for negative.
// R14: standstill check trips once position leaves tolerance window around reference.
// R15: three independent standstill elements.
// R16: position-based checks unavailable with two proximity switches.
// R17: torque-removal stop drops braking-ramp output immediately on trigger.
// R18: torque-removal stop drops torque on delay expiry or standstill speed.
// R19: at most one torque-removal stop element.
// R20: position-hold stop drops braking-ramp output immediately on trigger.
// R21: position-hold stop starts standstill check and raises position output.
// R22: leaving hold window drops position output and torque output.
// R23: hysteresis applies when a monitoring output switches back on.
// R24: automatic limit output returns once speed falls below limit with hysteresis.
// R25: after reset or fault every output stays off until inputs are valid.
module asmm_top #(
  parameter int unsigned TICK_CYC = asmm_pkg::TICK_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic cfg_valid_in,
  input wire logic fault_in,
  input wire logic two_prox_in,
  input wire logic speed_valid_in,
  input wire logic [asmm_pkg::SPD_W-1:0] speed_in,
  input wire logic signed [asmm_pkg::POS_W-1:0] position_in,
  input wire logic reset_in,
  input wire logic [asmm_pkg::SPD_W-1:0] hyst_in,
  input wire logic [asmm_pkg::TIM_W-1:0] tol_time_in,
  input wire logic [asmm_pkg::TIM_W-1:0] tol_period_in,
  input wire logic [asmm_pkg::PCT_W-1:0] tol_pct_in,
  input wire logic [asmm_pkg::NUM_LIM-1:0][asmm_pkg::SPD_W-1:0] lim_val_in,
  input wire logic [asmm_pkg::NUM_LIM-1:0] lim_manual_in,
  input wire logic [asmm_pkg::NUM_RNG-1:0][asmm_pkg::SPD_W-1:0] rng_min_in,
  input wire logic [asmm_pkg::NUM_RNG-1:0][asmm_pkg::SPD_W-1:0] rng_max_in,
  input wire logic [asmm_pkg::NUM_RNG-1:0] rng_manual_in,
  input wire logic [asmm_pkg::NUM_DIR-1:0] dir_start_in,
  input wire logic [asmm_pkg::POS_W-1:0] dir_tol_in,
  input wire logic [asmm_pkg::NUM_SOS-1:0] sos_start_in,
  input wire logic [asmm_pkg::POS_W-1:0] sos_tol_in,
  input wire logic [asmm_pkg::SPD_W-1:0] standstill_lim_in,
  input wire logic ss1_trig_in,
  input wire logic [asmm_pkg::TIM_W-1:0] ss1_delay_in,
  input wire logic ss2_trig_in,
  input wire logic [asmm_pkg::TIM_W-1:0] ss2_delay_in,
  input wire logic [asmm_pkg::POS_W-1:0] hold_tol_in,
  output logic [asmm_pkg::NUM_LIM-1:0] lim_en_out,
  output logic [asmm_pkg::NUM_RNG-1:0] rng_en_out,
  output logic [asmm_pkg::NUM_DIR-1:0] dir_ok_out,
  output logic [asmm_pkg::NUM_SOS-1:0] sos_ok_out,
  output logic ss1_ramp_out,
  output logic ss1_torque_out,
  output logic ss2_ramp_out,
  output logic ss2_posmon_out,
  output logic ss2_torque_out
);
  typedef struct packed {
    logic [asmm_pkg::TIM_W-1:0] tick_cnt;
    logic tick;
    logic [asmm_pkg::NUM_LIM-1:0] lim_en;
    logic [asmm_pkg::NUM_RNG-1:0] rng_en;
    logic [asmm_pkg::NUM_DIR-1:0] dir_ok;
    logic [asmm_pkg::NUM_DIR-1:0] dir_start_q;
    logic [asmm_pkg::NUM_DIR-1:0][asmm_pkg::POS_W-1:0] dir_ref;
    logic [asmm_pkg::NUM_SOS-1:0] sos_ok;
    logic [asmm_pkg::NUM_SOS-1:0] sos_start_q;
    logic [asmm_pkg::NUM_SOS-1:0][asmm_pkg::POS_W-1:0] sos_ref;
    asmm_pkg::asmm_stop_t ss1_st;
    logic [asmm_pkg::TIM_W-1:0] ss1_cnt;
    logic ss1_ramp;
    logic ss1_torque;
    asmm_pkg::asmm_stop_t ss2_st;
    logic [asmm_pkg::TIM_W-1:0] ss2_cnt;
    logic [asmm_pkg::POS_W-1:0] ss2_ref;
    logic ss2_ramp;
    logic ss2_posmon;
    logic ss2_torque;
  } asmm_st_t;
  asmm_st_t r, n;
  logic safe;
  logic stand;
  logic [asmm_pkg::NUM_TOL-1:0] tol_over;
  logic [asmm_pkg::NUM_TOL-1:0] tol_exc;
  logic [asmm_pkg::NUM_TOL-1:0] tol_viol;
  // ****************************************************************
  // arithmetic helpers
  // ****************************************************************
  // limit raised by the tolerance amount; wide enough never to wrap
  function automatic logic [asmm_pkg::EXT_W-1:0] f_exc_hi(
    input logic [asmm_pkg::SPD_W-1:0] lim, input logic [asmm_pkg::PCT_W-1:0] pct);
    logic [asmm_pkg::SPD_W+asmm_pkg::PCT_W-1:0] prod;
    prod = lim * pct;
    return asmm_pkg::EXT_W'(lim) + asmm_pkg::EXT_W'(prod / asmm_pkg::PCT_FULL);
  endfunction
  // limit lowered by the tolerance amount, floored at zero
  function automatic logic [asmm_pkg::EXT_W-1:0] f_exc_lo(
    input logic [asmm_pkg::SPD_W-1:0] lim, input logic [asmm_pkg::PCT_W-1:0] pct);
    logic [asmm_pkg::SPD_W+asmm_pkg::PCT_W-1:0] prod;
    prod = lim * pct;
    prod = (asmm_pkg::SPD_W+asmm_pkg::PCT_W)'(prod / asmm_pkg::PCT_FULL);
    return (prod > lim) ? '0 : asmm_pkg::EXT_W'(lim) - asmm_pkg::EXT_W'(prod);
  endfunction
  // signed distance of position from reference, one bit wider
  function automatic logic signed [asmm_pkg::POS_W:0] f_dist(
    input logic [asmm_pkg::POS_W-1:0] pos, input logic [asmm_pkg::POS_W-1:0] ref_pos);
    return $signed({pos[asmm_pkg::POS_W-1], pos}) - $signed({ref_pos[asmm_pkg::POS_W-1], ref_pos});
  endfunction
  // true when position has left the window of half-width tol
  function automatic logic f_out_win(
    input logic [asmm_pkg::POS_W-1:0] pos, input logic [asmm_pkg::POS_W-1:0] ref_pos,
    input logic [asmm_pkg::POS_W-1:0] tol);
    logic signed [asmm_pkg::POS_W:0] d;
    logic signed [asmm_pkg::POS_W:0] t;
    d = f_dist(pos, ref_pos);
    t = $signed({1'b0, tol});
    return (d > t) || (d < -t);
  endfunction
  // ****************************************************************
  // overshoot judges, one per limit and one per range
  // ****************************************************************
  assign safe = !cfg_valid_in || fault_in || !speed_valid_in; // R25
  assign stand = speed_in < standstill_lim_in;
  for (genvar i = 0; i < asmm_pkg::NUM_TOL; i++) begin : g_tol
    if (i < asmm_pkg::NUM_LIM) begin : g_lim
      assign tol_over[i] = speed_in > lim_val_in[i]; // R01
      assign tol_exc[i] = asmm_pkg::EXT_W'(speed_in) > f_exc_hi(lim_val_in[i], tol_pct_in);
    end else begin : g_rng
      localparam int J = i - asmm_pkg::NUM_LIM;
      assign tol_over[i] = speed_in > rng_max_in[J] || speed_in < rng_min_in[J]; // R07
      assign tol_exc[i] = asmm_pkg::EXT_W'(speed_in) > f_exc_hi(rng_max_in[J], tol_pct_in)
        || asmm_pkg::EXT_W'(speed_in) < f_exc_lo(rng_min_in[J], tol_pct_in);
    end
    asmm_tol u_tol (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .tick_in(r.tick),
      .over_in(tol_over[i]),
      .excess_in(tol_exc[i]),
      .t1_in(tol_time_in),
      .t2_in(tol_period_in),
      .viol_out(tol_viol[i])
    );
  end
  // ****************************************************************
  // next-state logic
  // ****************************************************************
  always_comb begin
    n = r;
    // time base for tolerance and stop delays
    n.tick = 1'b0;
    if (r.tick_cnt >= asmm_pkg::TIM_W'(TICK_CYC - 1)) begin
      n.tick_cnt = '0;
      n.tick = 1'b1;
    end else begin
      n.tick_cnt = r.tick_cnt + 1'b1;
    end
    // speed limits: hysteresis only gates the return to on
    for (int i = 0; i < asmm_pkg::NUM_LIM; i++) begin // R03
      if (tol_viol[i]) begin
        n.lim_en[i] = 1'b0; // R01
      end else if (!r.lim_en[i] && asmm_pkg::EXT_W'(speed_in) + asmm_pkg::EXT_W'(hyst_in)
          <= asmm_pkg::EXT_W'(lim_val_in[i])) begin // R23
        if (!lim_manual_in[i] || reset_in) begin
          n.lim_en[i] = 1'b1; // R02 R24
        end
      end
    end
    // speed ranges: inside by the hysteresis margin at both ends
    for (int j = 0; j < asmm_pkg::NUM_RNG; j++) begin // R10
      if (tol_viol[asmm_pkg::NUM_LIM + j]) begin
        n.rng_en[j] = 1'b0; // R07
      end else if (!r.rng_en[j]
          && asmm_pkg::EXT_W'(speed_in) + asmm_pkg::EXT_W'(hyst_in)
          <= asmm_pkg::EXT_W'(rng_max_in[j])
          && asmm_pkg::EXT_W'(speed_in)
          >= asmm_pkg::EXT_W'(rng_min_in[j]) + asmm_pkg::EXT_W'(hyst_in)) begin // R23
        if (!rng_manual_in[j] || reset_in) begin
          n.rng_en[j] = 1'b1; // R08 R09
        end
      end
    end
    // direction elements: index 0 may move positive, index 1 negative
    n.dir_start_q = dir_start_in;
    for (int d = 0; d < asmm_pkg::NUM_DIR; d++) begin // R13
      if (dir_start_in[d] && !r.dir_start_q[d]) begin
        n.dir_ok[d] = 1'b1; // R12
        n.dir_ref[d] = position_in;
      end else if (r.dir_ok[d]) begin
        if (d == asmm_pkg::DIR_POS
            && f_dist(position_in, r.dir_ref[d]) < -$signed({1'b0, dir_tol_in})) begin
          n.dir_ok[d] = 1'b0; // R11
        end
        if (d == asmm_pkg::DIR_NEG
            && f_dist(position_in, r.dir_ref[d]) > $signed({1'b0, dir_tol_in})) begin
          n.dir_ok[d] = 1'b0; // R11
        end
      end
    end
    // standstill elements latch the reference on each start edge
    n.sos_start_q = sos_start_in;
    for (int s = 0; s < asmm_pkg::NUM_SOS; s++) begin // R15
      if (sos_start_in[s] && !r.sos_start_q[s]) begin
        n.sos_ok[s] = 1'b1; // R12
        n.sos_ref[s] = position_in;
      end else if (r.sos_ok[s] && f_out_win(position_in, r.sos_ref[s], sos_tol_in)) begin
        n.sos_ok[s] = 1'b0; // R14
      end
    end
    // no position from two proximity switches, so these stay off
    if (two_prox_in) begin
      n.dir_ok = '0; // R16
      n.sos_ok = '0; // R16
    end
    // single torque-removal stop sequence
    case (r.ss1_st) // R19
      asmm_pkg::ST_IDLE: begin
        n.ss1_ramp = 1'b1;
        n.ss1_torque = 1'b1;
        if (ss1_trig_in) begin
          n.ss1_st = asmm_pkg::ST_RAMP;
          n.ss1_ramp = 1'b0; // R17
          n.ss1_cnt = '0;
        end
      end
      asmm_pkg::ST_RAMP: begin
        if (!ss1_trig_in) begin
          n.ss1_st = asmm_pkg::ST_IDLE;
        end else if (r.ss1_cnt >= ss1_delay_in || stand) begin
          n.ss1_st = asmm_pkg::ST_TRIP;
          n.ss1_torque = 1'b0; // R18
        end else if (r.tick) begin
          n.ss1_cnt = r.ss1_cnt + 1'b1;
        end
      end
      asmm_pkg::ST_TRIP: begin
        if (!ss1_trig_in) begin
          n.ss1_st = asmm_pkg::ST_IDLE;
        end
      end
      default: begin
        n.ss1_st = asmm_pkg::ST_IDLE;
      end
    endcase
    // position-hold stop sequence; torque stays on while holding
    case (r.ss2_st)
      asmm_pkg::ST_IDLE: begin
        n.ss2_ramp = 1'b1;
        n.ss2_posmon = 1'b0;
        n.ss2_torque = 1'b1;
        if (ss2_trig_in) begin
          n.ss2_st = asmm_pkg::ST_RAMP;
          n.ss2_ramp = 1'b0; // R20
          n.ss2_cnt = '0;
        end
      end
      asmm_pkg::ST_RAMP: begin
        if (!ss2_trig_in) begin
          n.ss2_st = asmm_pkg::ST_IDLE;
        end else if (r.ss2_cnt >= ss2_delay_in || stand) begin
          if (two_prox_in) begin
            n.ss2_st = asmm_pkg::ST_TRIP; // R16
            n.ss2_torque = 1'b0;
          end else begin
            n.ss2_st = asmm_pkg::ST_HOLD;
            n.ss2_posmon = 1'b1; // R21
            n.ss2_ref = position_in;
          end
        end else if (r.tick) begin
          n.ss2_cnt = r.ss2_cnt + 1'b1;
        end
      end
      asmm_pkg::ST_HOLD: begin
        if (!ss2_trig_in) begin
          n.ss2_st = asmm_pkg::ST_IDLE;
        end else if (f_out_win(position_in, r.ss2_ref, hold_tol_in)) begin
          n.ss2_st = asmm_pkg::ST_TRIP;
          n.ss2_posmon = 1'b0; // R22
          n.ss2_torque = 1'b0; // R22
        end
      end
      asmm_pkg::ST_TRIP: begin
        if (!ss2_trig_in) begin
          n.ss2_st = asmm_pkg::ST_IDLE;
        end
      end
      default: begin
        n.ss2_st = asmm_pkg::ST_IDLE;
      end
    endcase
    // invalid inputs force every output off and park the sequences
    if (safe) begin // R25
      n.lim_en = '0;
      n.rng_en = '0;
      n.dir_ok = '0;
      n.sos_ok = '0;
      n.ss1_st = asmm_pkg::ST_IDLE;
      n.ss1_ramp = asmm_pkg::RST_OUT;
      n.ss1_torque = asmm_pkg::RST_OUT;
      n.ss2_st = asmm_pkg::ST_IDLE;
      n.ss2_ramp = asmm_pkg::RST_OUT;
      n.ss2_posmon = asmm_pkg::RST_OUT;
      n.ss2_torque = asmm_pkg::RST_OUT;
    end
  end
  // ****************************************************************
  // state register and outputs
  // ****************************************************************
  // all-zero reset is the safe state: every output off
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r <= '0; // R25
    end else begin
      r <= n;
    end
  end
  assign lim_en_out = r.lim_en;
  assign rng_en_out = r.rng_en;
  assign dir_ok_out = r.dir_ok;
  assign sos_ok_out = r.sos_ok;
  assign ss1_ramp_out = r.ss1_ramp;
  assign ss1_torque_out = r.ss1_torque;
  assign ss2_ramp_out = r.ss2_ramp;
  assign ss2_posmon_out = r.ss2_posmon;
  assign ss2_torque_out = r.ss2_torque;
  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_ss1_go;
    !safe && r.ss1_st == asmm_pkg::ST_IDLE && ss1_trig_in;
  endsequence
  sequence s_ss2_settle;
    !safe && ss2_trig_in && !two_prox_in && r.ss2_st == asmm_pkg::ST_RAMP
      && (r.ss2_cnt >= ss2_delay_in || stand);
  endsequence
  AST_SAFE_OFF: assert property (safe |=> lim_en_out == '0 && !ss1_torque_out // R25
    && !ss2_torque_out && rng_en_out == '0) else $error("outputs not off while invalid");
  AST_LIM_OFF: assert property (tol_viol[0] |=> !lim_en_out[0]) // R01
    else $error("limit enable kept on during violation");
  AST_LIM_MANUAL: assert property (lim_manual_in[0] && !reset_in && !lim_en_out[0] // R02
    |=> !lim_en_out[0]) else $error("manual limit output returned without reset");
  AST_RNG_OFF: assert property (tol_viol[asmm_pkg::NUM_LIM] |=> !rng_en_out[0]) // R07
    else $error("range enable kept on during violation");
  AST_PROX: assert property (two_prox_in |=> dir_ok_out == '0 && sos_ok_out == '0) // R16
    else $error("position check active with proximity switches");
  AST_SOS_ARM: assert property ($rose(sos_start_in[0]) && !safe && !two_prox_in // R12
    |=> sos_ok_out[0] && r.sos_ref[0] == $past(position_in)) else $error("standstill not armed");
  AST_SS1_RAMP: assert property (s_ss1_go |=> !ss1_ramp_out && ss1_torque_out) // R17
    else $error("braking ramp not dropped on trigger");
  AST_SS1_STO: assert property (!safe && ss1_trig_in && r.ss1_st == asmm_pkg::ST_RAMP // R18
    && stand |=> !ss1_torque_out) else $error("torque not removed at standstill");
  AST_SS2_HOLD: assert property (s_ss2_settle |=> ss2_posmon_out ##1 // R21
    (ss2_posmon_out || !ss2_torque_out || !ss2_trig_in || safe))
    else $error("position hold not entered");
  AST_SS2_TRIP: assert property (!safe && ss2_trig_in && r.ss2_st == asmm_pkg::ST_HOLD // R22
    && f_out_win(position_in, r.ss2_ref, hold_tol_in)
    |=> !ss2_posmon_out && !ss2_torque_out) else $error("hold window exit not tripped");
endmodule

// >>> sim/asmm_drive.sv
// drive controller model: speed follows the command, ramps down while braking
module asmm_drive (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic brake_n_in,
  input wire logic [asmm_pkg::SPD_W-1:0] cmd_in,
  output logic [asmm_pkg::SPD_W-1:0] speed_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // fixed ramp of 16 per clock, so any stop reaches standstill in bounded time
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      speed_out <= '0;
    end else if (!brake_n_in) begin
      speed_out <= (speed_out > 16'h0010) ? speed_out - 16'h0010 : 16'h0000;
    end else begin
      speed_out <= cmd_in;
    end
  end
endmodule

// >>> sim/tb.sv
// self-checking testbench of the axis safe motion monitor
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic cfg_v = 1'b1, flt = 1'b0, prox2 = 1'b0, btn = 1'b0, tr1 = 1'b0, tr2 = 1'b0;
  logic [15:0] speed, cmd = 16'h003c, hyst = 16'h000a, t1 = '0, t2 = '0;
  logic [15:0] slim = '0, d1 = '0, d2 = '0;
  logic [7:0] pct = '0;
  logic spv = 1'b1;
  logic signed [31:0] pos = '0;
  logic [31:0] tol = 32'h0000_0014;
  logic [11:0][15:0] lim;
  logic [11:0] lman = '0, lim_en;
  logic [1:0][15:0] rmin = {16'h03e8, 16'h0032}, rmax = {16'h07d0, 16'h0190};
  logic [1:0] rman = 2'b10, dst = '0, rng_en, dir_ok;
  logic [2:0] sst = '0, sos_ok;
  logic r1, q1, r2, pm2, q2;
  int err_count = 0;
  int n_compared = 0;
  // clock of 4 ns
  always #2 clk_in = ~clk_in;
  asmm_drive DRV (.clk_in(clk_in), .rst_n_in(rst_n_in), .brake_n_in(r1 & r2),
    .cmd_in(cmd), .speed_out(speed));
  // short tick of 4 clocks keeps tolerance and delay runs brief
  asmm_top #(.TICK_CYC(4)) DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .cfg_valid_in(cfg_v),
    .fault_in(flt), .two_prox_in(prox2), .speed_valid_in(spv), .speed_in(speed),
    .position_in(pos), .reset_in(btn), .hyst_in(hyst), .tol_time_in(t1),
    .tol_period_in(t2), .tol_pct_in(pct), .lim_val_in(lim), .lim_manual_in(lman),
    .rng_min_in(rmin), .rng_max_in(rmax), .rng_manual_in(rman), .dir_start_in(dst),
    .dir_tol_in(tol), .sos_start_in(sst), .sos_tol_in(tol), .standstill_lim_in(slim),
    .ss1_trig_in(tr1), .ss1_delay_in(d1), .ss2_trig_in(tr2), .ss2_delay_in(d2),
    .hold_tol_in(tol), .lim_en_out(lim_en), .rng_en_out(rng_en), .dir_ok_out(dir_ok),
    .sos_ok_out(sos_ok), .ss1_ramp_out(r1), .ss1_torque_out(q1), .ss2_ramp_out(r2),
    .ss2_posmon_out(pm2), .ss2_torque_out(q2));
  // inputs always change 1 ns after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // bounded wait: sel 0 for torque removal, sel 1 for hold monitoring on
  task automatic wait_for(input int sel, input int lim_c, output int n);
    n = 0;
    while ((sel == 0 ? q1 !== 1'b0 : pm2 !== 1'b1) && n < lim_c) begin
      cyc(1);
      n++;
    end
    if (n >= lim_c) begin
      chk("wait bound", 32'h0, 32'h1);
      test_done();
    end
  endtask
  // main sequence
  initial begin
    int n;
    for (int i = 0; i < 12; i++) begin
      lim[i] = 16'(100 * (i + 1));
    end
    cyc(4);
    chk("outs in reset", 32'h0, {lim_en, rng_en, q1, r1});
    cyc(1);
    rst_n_in = 1'b1;
    cyc(8);
    chk("limits", 32'hfff, lim_en);
    chk("ranges", 32'h1, rng_en);
    chk("stop outs", 32'hf, {r1, q1, r2, q2});
    cmd = 16'h015e;
    cyc(8);
    chk("over", 32'hff8, lim_en);
    cmd = 16'h005f;
    cyc(8);
    chk("hyst", 32'hffe, lim_en);
    lman = 12'h001;
    cmd = 16'h0050;
    cyc(8);
    chk("manual hold", 32'hffe, lim_en);
    btn = 1'b1;
    cyc(4);
    chk("manual ok", 32'hfff, lim_en);
    btn = 1'b0;
    lman = '0;
    cmd = 16'h01c2;
    cyc(8);
    chk("range out", 32'h0, rng_en);
    cmd = 16'h05dc;
    cyc(8);
    chk("range manual", 32'h0, rng_en);
    btn = 1'b1;
    cyc(4);
    chk("range reset", 32'h2, rng_en);
    btn = 1'b0;
    cmd = 16'h0050;
    cyc(8);
    chk("range auto", 32'h1, rng_en);
    $display("test speed done");
    pct = 8'h32;
    t1 = 16'h0002;
    cmd = 16'h02bc;
    cyc(4);
    chk("excess", 32'h0, lim_en[3]);
    t2 = 16'h000a;
    cmd = 16'h0050;
    cyc(60);
    cmd = 16'h01c2;
    cyc(5);
    chk("short over", 32'h1, lim_en[3]);
    cyc(16);
    chk("long over", 32'h0, lim_en[3]);
    cmd = 16'h0050;
    cyc(24);
    cmd = 16'h01c2;
    cyc(3);
    chk("close repeat", 32'h0, lim_en[3]);
    cmd = 16'h0050;
    $display("test tolerance done");
    pos = 32'h0000_03e8;
    dst = 2'b11;
    sst = 3'b111;
    cyc(3);
    chk("armed", 32'h1f, {dir_ok, sos_ok});
    pos = 32'h0000_03fc;
    cyc(3);
    chk("window edge", 32'h1f, {dir_ok, sos_ok});
    pos = 32'h0000_0406;
    cyc(3);
    chk("moved", 32'h08, {dir_ok, sos_ok});
    sst = 3'b011;
    dst = 2'b01;
    cyc(1);
    sst = 3'b111;
    dst = 2'b11;
    cyc(3);
    chk("rearm", 32'h1c, {dir_ok, sos_ok});
    prox2 = 1'b1;
    dst = '0;
    sst = '0;
    cyc(2);
    dst = 2'b11;
    sst = 3'b111;
    cyc(3);
    chk("two prox", 32'h0, {dir_ok, sos_ok});
    prox2 = 1'b0;
    $display("test position done");
    slim = 16'h0008;
    d1 = 16'h0064;
    cmd = 16'h01f4;
    cyc(4);
    tr1 = 1'b1;
    cyc(1);
    chk("ss1 ramp", 32'h0, r1);
    wait_for(0, 200, n);
    chk("ss1 stand", 32'h1, n < 100);
    tr1 = 1'b0;
    cyc(3);
    chk("ss1 idle", 32'h3, {r1, q1});
    slim = '0;
    d1 = 16'h0002;
    tr1 = 1'b1;
    cyc(1);
    wait_for(0, 40, n);
    chk("ss1 delay", 32'h1, n > 4);
    tr1 = 1'b0;
    slim = 16'h0008;
    d2 = 16'h0064;
    pos = 32'h0000_07d0;
    cyc(6);
    tr2 = 1'b1;
    cyc(1);
    chk("ss2 ramp", 32'h0, r2);
    wait_for(1, 200, n);
    chk("ss2 hold", 32'h1, q2);
    pos = 32'h0000_07ee;
    cyc(3);
    chk("ss2 exit", 32'h0, {pm2, q2});
    tr2 = 1'b0;
    $display("test stops done");
    cmd = 16'h003c;
    flt = 1'b1;
    cyc(3);
    chk("fault", 32'h0, {lim_en, q1});
    flt = 1'b0;
    spv = 1'b0;
    cyc(3);
    chk("no speed", 32'h0, {lim_en, r1, q2});
    spv = 1'b1;
    cfg_v = 1'b0;
    cyc(3);
    chk("no config", 32'h0, {lim_en, r2});
    cfg_v = 1'b1;
    cyc(8);
    chk("recover", 32'hfff, lim_en);
    $display("test safe state done");
    test_done();
  end
endmodule
